// *** hw/pil_limiter.sv ***
// Parameter register and issue limiting for the background preload engine
`timescale 1ns/1ps
`include "pil_consts.svh"
module pil_limiter #(
  parameter bit HAS_PRELOAD = 1'b1,
  parameter int SIZE_W = 14,
  parameter int CNT_W = 8,
  parameter int GAP_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc1,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_privileged,
  input wire logic cp_nonsecure,
  input wire logic nonsecure_preload_permit,
  output logic [31:0] cp_rdata,
  output logic cp_hit,
  output logic cp_undef,
  input wire logic launch,
  input wire logic [SIZE_W-1:0] req_block_size,
  input wire logic [CNT_W-1:0] req_block_number,
  output logic [SIZE_W-1:0] eff_block_size,
  output logic [CNT_W-1:0] eff_block_number,
  input wire logic preload_want,
  output logic preload_grant,
  output pil_pkg::pil_state_t gap_state
);
  import pil_pkg::*;

  if (SIZE_W != `PIL_SIZE_HI - `PIL_SIZE_LO + 1) begin : g_bad_size
    $error("SIZE_W mismatch");
  end
  if (CNT_W != `PIL_CNT_HI - `PIL_CNT_LO + 1) begin : g_bad_cnt
    $error("CNT_W mismatch");
  end
  if (GAP_W != `PIL_GAP_HI - `PIL_GAP_LO + 1) begin : g_bad_gap
    $error("GAP_W mismatch");
  end

  // ============================================================
  // Register access
  logic [31:0] param_q;
  logic sel;
  logic allowed;
  logic [SIZE_W-1:0] size_mask;
  logic [CNT_W-1:0] cnt_mask;
  logic [GAP_W-1:0] gap;

  assign sel = cp_valid && cp_crn == `PIL_CRN && cp_crm == `PIL_CRM
               && cp_opc1 == `PIL_OPC1 && cp_opc2 == `PIL_OPC2;
  assign allowed = cp_privileged && (!cp_nonsecure || nonsecure_preload_permit);
  assign cp_hit = sel && HAS_PRELOAD && allowed;
  assign cp_undef = sel && (!HAS_PRELOAD || !allowed);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      param_q <= `PIL_RESET;
    end else if (cp_hit && cp_write) begin
      param_q <= cp_wdata & `PIL_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cp_rdata <= '0;
    end else if (cp_hit && !cp_write) begin
      cp_rdata <= param_q;
    end
  end

  assign size_mask = param_q[`PIL_SIZE_HI:`PIL_SIZE_LO];
  assign cnt_mask = param_q[`PIL_CNT_HI:`PIL_CNT_LO];
  assign gap = param_q[`PIL_GAP_HI:`PIL_GAP_LO];

  // ============================================================
  // Transfer limits at launch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eff_block_size <= '0;
      eff_block_number <= '0;
    end else if (launch) begin
      eff_block_size <= req_block_size & size_mask;
      eff_block_number <= req_block_number & cnt_mask;
    end
  end

  // ============================================================
  // Issue rate
  logic gap_ready;
  pil_state_t state_q;
  pil_state_t state_d;

  pil_gap_counter #(
    .GAP_W(GAP_W)
  ) u_gap (
    .core_clk(core_clk),
    .resetn(resetn),
    .gap(gap),
    .issued(preload_grant),
    .ready(gap_ready)
  );

  assign preload_grant = preload_want && gap_ready;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PIL_IDLE: begin
        if (preload_grant) state_d = (gap == '0) ? PIL_ISSUE : PIL_WAIT;
      end
      PIL_ISSUE: begin
        if (preload_grant) state_d = (gap == '0) ? PIL_ISSUE : PIL_WAIT;
        else state_d = PIL_IDLE;
      end
      PIL_WAIT: begin
        if (preload_grant) state_d = (gap == '0) ? PIL_ISSUE : PIL_WAIT;
        else if (gap_ready) state_d = PIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PIL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign gap_state = state_q;

  // ============================================================
  // Issue spacing monitor
  logic [GAP_W:0] since_grant_q;
  logic [GAP_W-1:0] gap_at_grant_q;
  logic seen_grant_q;

  // Cycles since the last grant, saturating, and the gap in force then
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      since_grant_q <= '0;
      gap_at_grant_q <= '0;
      seen_grant_q <= 1'b0;
    end else if (preload_grant) begin
      since_grant_q <= {{GAP_W{1'b0}}, 1'b1};
      gap_at_grant_q <= gap;
      seen_grant_q <= 1'b1;
    end else if (since_grant_q != '1) begin
      since_grant_q <= since_grant_q + 1'b1;
    end
  end

  // ============================================================
  // Checks
  property p_size_mask;
    @(posedge core_clk) disable iff (!resetn)
      launch |=> eff_block_size == ($past(req_block_size) & $past(size_mask));
  endproperty
  a_size_mask: assert property (p_size_mask) else $error("size mask wrong");

  property p_size_zero;
    @(posedge core_clk) disable iff (!resetn)
      launch && size_mask == '0 |=> eff_block_size == '0;
  endproperty
  a_size_zero: assert property (p_size_zero) else $error("zero size mask leak");

  property p_cnt_mask;
    @(posedge core_clk) disable iff (!resetn)
      launch |=> eff_block_number == ($past(req_block_number) & $past(cnt_mask));
  endproperty
  a_cnt_mask: assert property (p_cnt_mask) else $error("count mask wrong");

  property p_cnt_zero;
    @(posedge core_clk) disable iff (!resetn)
      launch && cnt_mask == '0 |=> eff_block_number == '0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("zero count mask leak");

  property p_gap_ff;
    @(posedge core_clk) disable iff (!resetn)
      preload_grant && gap == 8'hff && $stable(gap) |=> !preload_grant [*8];
  endproperty
  a_gap_ff: assert property (p_gap_ff) else $error("issue too soon");

  property p_gap_zero;
    @(posedge core_clk) disable iff (!resetn)
      preload_grant && gap == '0 ##1 preload_want |-> preload_grant;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("back to back refused");

  property p_write;
    @(posedge core_clk) disable iff (!resetn)
      cp_hit && cp_write |=> param_q == ($past(cp_wdata) & `PIL_WR_MASK);
  endproperty
  a_write: assert property (p_write) else $error("write lost");

  property p_priv;
    @(posedge core_clk) disable iff (!resetn)
      sel && (!cp_privileged || (cp_nonsecure && !nonsecure_preload_permit)) |-> cp_undef;
  endproperty
  a_priv: assert property (p_priv) else $error("unprivileged access passed");

  property p_absent;
    @(posedge core_clk) disable iff (!resetn)
      sel && !HAS_PRELOAD |-> cp_undef && !cp_hit;
  endproperty
  a_absent: assert property (p_absent) else $error("absent engine reached");

  property p_reload;
    @(posedge core_clk) disable iff (!resetn)
      preload_grant && gap == 8'h02 |=> !preload_grant ##1 !preload_grant;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");

  property p_spacing;
    @(posedge core_clk) disable iff (!resetn)
      preload_grant && seen_grant_q |-> since_grant_q > {1'b0, gap_at_grant_q};
  endproperty
  a_spacing: assert property (p_spacing) else $error("grant inside gap");

  property p_read;
    @(posedge core_clk) disable iff (!resetn)
      cp_hit && !cp_write |=> cp_rdata == $past(param_q);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  c_write: cover property (@(posedge core_clk) cp_hit && cp_write);
  c_read: cover property (@(posedge core_clk) cp_hit && !cp_write);
  c_launch: cover property (@(posedge core_clk) launch && size_mask != '0);
  c_wait: cover property (@(posedge core_clk) state_q == PIL_WAIT ##1 preload_grant);
endmodule // pil_limiter

// *** hw/pil_consts.svh ***
// Constants for the preload issue limiter
// What this block does
// - Size mask bits 29:16 ANDed with size
// - Size in words; zero mask gives zero
// - Count mask bits 15:8 ANDed with count
// - Count field is blocks minus one
// - Gap field bits 7:0 sets idle cycles
// - All-ones gap gives one request per 256
// - Register read/write at c11, c1, opcode 1
// - Privileged only; non-secure needs permit bit
// - No preload engine means undefined instruction
`ifndef PIL_CONSTS_SVH
`define PIL_CONSTS_SVH
// ============================================================
// Register selection
`define PIL_CRN 4'hb
`define PIL_CRM 4'h1
`define PIL_OPC1 3'h0
`define PIL_OPC2 3'h1
// ============================================================
// Field layout
`define PIL_SIZE_HI 29
`define PIL_SIZE_LO 16
`define PIL_CNT_HI 15
`define PIL_CNT_LO 8
`define PIL_GAP_HI 7
`define PIL_GAP_LO 0
`define PIL_WR_MASK 32'h3fff_ffff
`define PIL_RESET 32'h0000_0000
`endif

// *** hw/pil_pkg.sv ***
// Types for the preload issue limiter
package pil_pkg;
  typedef enum logic [1:0] {
    PIL_IDLE,
    PIL_ISSUE,
    PIL_WAIT
  } pil_state_t;
endpackage

// *** hw/pil_gap_counter.sv ***
// Down-counter enforcing the gap between preload requests
`timescale 1ns/1ps
module pil_gap_counter #(
  parameter int GAP_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [GAP_W-1:0] gap,
  input wire logic issued,
  output logic ready
);
  logic [GAP_W-1:0] cnt_q;
  if (GAP_W < 1) begin : g_bad_gap
    $error("GAP_W too small");
  end
  // Reload on issue, count idle cycles down
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (issued) begin
      cnt_q <= gap;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign ready = (cnt_q == '0);
  property p_gap_hold;
    @(posedge core_clk) disable iff (!resetn)
      issued && gap != '0 |=> !ready;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("gap not enforced");
endmodule // pil_gap_counter

// *** verification/pil_mem_model.sv ***
// Memory-side model that accepts preload requests and times them
`timescale 1ns/1ps
module pil_mem_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic preload_grant,
  output logic [8:0] spacing,
  output logic [7:0] grants
);
  logic [8:0] since_q;
  // ============================================================
  // Request acceptance
  // Accepts every request at once and records cycles since the previous one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      since_q <= 9'h001;
      spacing <= 9'h000;
      grants <= 8'h00;
    end else if (preload_grant) begin
      spacing <= since_q;
      since_q <= 9'h001;
      grants <= grants + 8'h01;
    end else begin
      since_q <= since_q + 9'h001;
    end
  end
endmodule // pil_mem_model

// *** verification/testbench.sv ***
// Self-checking testbench for the preload issue limiter
`timescale 1ns/1ps
`include "pil_consts.svh"
module testbench;
  import pil_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, cp_valid = 1'b0, cp_write = 1'b0, undef_b;
  logic cp_privileged = 1'b1, cp_nonsecure = 1'b0, nonsecure_preload_permit = 1'b0;
  logic launch = 1'b0, preload_want = 1'b0, cp_hit, cp_undef, preload_grant;
  logic [3:0] cp_crn = `PIL_CRN, cp_crm = `PIL_CRM;
  logic [2:0] cp_opc1 = `PIL_OPC1, cp_opc2 = `PIL_OPC2;
  logic [31:0] cp_wdata = '0, cp_rdata;
  logic [13:0] req_block_size = 14'h2aaa, eff_block_size;
  logic [7:0] req_block_number = 8'h5a, eff_block_number, grants;
  logic [8:0] spacing;
  pil_state_t gap_state;
  int mismatches = 0, checks_done = 0;
  // ============================================================
  // Instances
  pil_limiter u_pil_limiter (.*);
  pil_limiter #(.HAS_PRELOAD(1'b0)) u_pil_limiter_bare (.*, .cp_rdata(), .cp_hit(),
    .cp_undef(undef_b), .eff_block_size(), .eff_block_number(), .preload_grant(),
    .gap_state());
  pil_mem_model u_pil_mem_model (.*);
  initial forever #10 core_clk = ~core_clk;
  // ============================================================
  // Shared tasks
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One access; hu is the expected hit and refusal pair
  task automatic acc(logic w, logic [31:0] d, logic p, logic n, logic [1:0] hu);
    @(negedge core_clk);
    {cp_valid, cp_write, cp_wdata, cp_privileged, cp_nonsecure} = {1'b1, w, d, p, n};
    #1 check("hit_undef", 32'({cp_hit, cp_undef}), 32'(hu));
    check("absent_undef", 32'(undef_b), 32'(|hu));
    @(negedge core_clk);
    cp_valid = 1'b0;
  endtask
  task automatic rd(logic [31:0] exp);
    acc(1'b0, '0, 1'b1, 1'b0, 2'b10);
    check("rdata", cp_rdata, exp);
  endtask
  // ============================================================
  // Scenarios
  task automatic test_reg();
    rd(32'h0000_0000);
    acc(1'b1, 32'hffff_ffff, 1'b1, 1'b0, 2'b10);
    rd(32'h3fff_ffff);
    acc(1'b1, 32'h0000_0000, 1'b0, 1'b0, 2'b01);
    acc(1'b1, 32'h0000_0000, 1'b1, 1'b1, 2'b01);
    rd(32'h3fff_ffff);
    nonsecure_preload_permit = 1'b1;
    acc(1'b1, 32'h1234_5678, 1'b1, 1'b1, 2'b10);
    nonsecure_preload_permit = 1'b0;
    cp_opc2 = 3'h0;
    acc(1'b1, 32'h0000_0000, 1'b1, 1'b0, 2'b00);
    cp_opc2 = `PIL_OPC2;
    rd(32'h1234_5678);
    $display("test_reg done");
  endtask
  task automatic test_mask(logic [31:0] r);
    acc(1'b1, r, 1'b1, 1'b0, 2'b10);
    @(negedge core_clk);
    launch = 1'b1;
    @(negedge core_clk);
    launch = 1'b0;
    check("eff_size", 32'(eff_block_size), 32'(r[29:16] & 14'h2aaa));
    check("eff_number", 32'(eff_block_number), 32'(r[15:8] & 8'h5a));
    $display("test_mask done");
  endtask
  task automatic test_gap(int g);
    logic [7:0] b;
    acc(1'b1, 32'(g), 1'b1, 1'b0, 2'b10);
    b = grants;
    @(negedge core_clk);
    preload_want = 1'b1;
    @(negedge core_clk);
    check("state_run", 32'(gap_state), 32'((g == 0) ? PIL_ISSUE : PIL_WAIT));
    repeat (3 * (g + 1) - 1) @(negedge core_clk);
    preload_want = 1'b0;
    check("grants", 32'(8'(grants - b)), 32'h0000_0003);
    check("spacing", 32'(spacing), 32'(g + 1));
    repeat (g + 1) @(negedge core_clk);
    check("state_idle", 32'(gap_state), 32'(PIL_IDLE));
    $display("test_gap done");
  endtask
  task automatic test_reset();
    @(negedge core_clk);
    resetn = 1'b0;
    #1 check("rst_size", 32'(eff_block_size), 32'h0000_0000);
    check("rst_rdata", cp_rdata, 32'h0000_0000);
    @(negedge core_clk);
    resetn = 1'b1;
    rd(32'h0000_0000);
    $display("test_reset done");
  endtask
  // ============================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    test_reg();
    test_mask(32'h0035_0300);
    test_mask(32'h0000_0000);
    test_mask(32'h3fff_ff00);
    test_gap(0);
    test_gap(2);
    test_gap(255);
    test_reset();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end
endmodule // testbench
